// file: verilog/nco_pkg.sv
// Behaviour
// R1: Accumulator is 20 bits over low, high and upper-nibble byte registers.
// R2: Bits 7:4 of both upper-nibble registers read as zero.
// R3: The accumulator has a 24-bit register space but keeps only 20 bits.
// R4: Accumulator moves on oscillator edges; multi-byte reads are not atomic.
// R5: Software must not write the accumulator while the oscillator runs.
// R6: Step is 20 bits over low, high and upper-nibble byte registers.
// R7: Reset sets the step to one: low byte 0x01, others zero.
// R8: Shadow takes the whole step on the oscillator falling edge after a low write.
// R9: Software writes upper and high step bytes before the low byte.
// R10: While disabled, any step write loads the shadow at once.
// R11: Overflow sets a sticky flag that software clears in its handler.
// R12: Each enabled rising edge adds the shadow modulo 2^20; carry means overflow.
package nco_pkg;
  localparam int ACC_W = 20;
  localparam int ADDR_W = 8;
  // Register byte addresses
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CLK_CFG = 8'h04;
  localparam logic [7:0] OFS_ACC_LOW = 8'h08;
  localparam logic [7:0] OFS_ACC_HIGH = 8'h0C;
  localparam logic [7:0] OFS_ACC_UPPER = 8'h10;
  localparam logic [7:0] OFS_STEP_LOW = 8'h14;
  localparam logic [7:0] OFS_STEP_HIGH = 8'h18;
  localparam logic [7:0] OFS_STEP_UPPER = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  // Control field positions
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_PFM_BIT = 0;
  localparam logic [7:0] CLK_CFG_MASK = 8'hE3;
  localparam logic [7:0] UPPER_MASK = 8'h0F;
  // Values after reset
  localparam logic [ACC_W-1:0] STEP_RESET = 20'h00001;
  localparam logic [ACC_W-1:0] ACC_RESET = 20'h00000;
  localparam logic [7:0] CLK_CFG_RESET = 8'h00;
  // Byte lanes of the accumulator
  typedef enum logic [1:0] {
    LANE_LOW = 2'b00,
    LANE_HIGH = 2'b01,
    LANE_UPPER = 2'b10
  } lane_t;
  // One software write into the accumulator
  typedef struct packed {
    logic valid;
    lane_t lane;
    logic [7:0] data;
  } acc_wr_t;
endpackage : nco_pkg

// file: verilog/nco_core.sv
`timescale 1ns/1ps
module nco_core
  import nco_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from the register file
  input wire logic enable,
  input wire logic osc_clk_in,
  input wire logic [ACC_W-1:0] phase_step,
  input wire logic step_low_wr,
  input wire logic step_any_wr,
  input wire acc_wr_t acc_wr,
  // State back to the register file
  output logic [ACC_W-1:0] phase_accumulator,
  output logic [ACC_W-1:0] step_shadow,
  output logic overflow
);
  logic osc_prev;
  logic rise;
  logic fall;
  logic pending;
  logic load_idle;
  logic [ACC_W:0] sum;

  // Edge detection on the oscillator input, sampled by pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_clk_in;
    end
  end
  assign rise = osc_clk_in & ~osc_prev;
  assign fall = ~osc_clk_in & osc_prev;
  assign sum = {1'b0, phase_accumulator} + {1'b0, step_shadow};

  // Low-byte write arms the shadow load; a new write beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    end else if (enable && step_low_wr) begin
      pending <= 1'b1; // see R8
    end else if (fall || !enable) begin
      pending <= 1'b0;
    end
  end

  // Idle load follows the write by one cycle so the step register is settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_idle <= 1'b0;
    end else begin
      load_idle <= step_any_wr & ~enable; // see R10
    end
  end

  // All three bytes move together, hence the low byte must come last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_shadow <= STEP_RESET; // see R7
    end else if (load_idle) begin
      step_shadow <= phase_step; // see R10
    end else if (enable && pending && fall) begin
      step_shadow <= phase_step; // see R8 see R9
    end
  end

  // Software write wins; writing while running gives no defined result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_accumulator <= ACC_RESET;
    end else if (acc_wr.valid) begin
      unique case (acc_wr.lane)
        LANE_LOW: phase_accumulator[7:0] <= acc_wr.data; // see R1 see R5
        LANE_HIGH: phase_accumulator[15:8] <= acc_wr.data; // see R1
        LANE_UPPER: phase_accumulator[19:16] <= acc_wr.data[3:0]; // see R1 see R3
        default: phase_accumulator <= phase_accumulator;
      endcase
    end else if (enable && rise) begin
      phase_accumulator <= sum[ACC_W-1:0]; // see R12 see R4
    end
  end

  // Carry out of the top bit is a one-cycle overflow pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow <= 1'b0;
    end else begin
      overflow <= enable & rise & ~acc_wr.valid & sum[ACC_W]; // see R12
    end
  end

  a_shadow_falling: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    (enable && pending && fall && !load_idle) |=> step_shadow == $past(phase_step))
    else $error("shadow did not load on falling edge");
  a_shadow_idle_load: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    (step_any_wr && !enable) |=> ##1 step_shadow == $past(phase_step))
    else $error("shadow not loaded after idle step write");
  a_acc_add_mod: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    (enable && rise && !acc_wr.valid) |=>
      phase_accumulator == ACC_W'($past(phase_accumulator) + $past(step_shadow)))
    else $error("accumulator add wrong");
  a_acc_holds_still: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (!(enable && rise) && !acc_wr.valid) |=> $stable(phase_accumulator))
    else $error("accumulator moved without edge");
  a_overflow_carry: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    overflow |-> $past(enable && rise && !acc_wr.valid) &&
      ($past(phase_accumulator) > phase_accumulator))
    else $error("overflow without carry");
  c_shadow_load: cover property (@(posedge pclk) disable iff (!presetn)
    enable && pending && fall);
  c_overflow: cover property (@(posedge pclk) disable iff (!presetn) overflow);
endmodule : nco_core

// file: verilog/nco_regs.sv
`timescale 1ns/1ps
module nco_regs
  import nco_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator input and results
  input wire logic oscillator_input_clock,
  output logic osc_out,
  output logic irq
);
  logic oscillator_enable;
  logic ctrl_pol;
  logic ctrl_pfm;
  logic [7:0] clk_cfg;
  logic [ACC_W-1:0] phase_step;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic out_toggle;
  logic [ACC_W-1:0] phase_accumulator;
  logic [ACC_W-1:0] step_shadow;
  logic overflow;
  logic setup;
  logic wr_now;
  logic mapped;
  logic [7:0] read_byte;
  logic step_low_wr;
  logic step_any_wr;
  acc_wr_t acc_wr;

  // Bus phases; the slave never waits
  assign setup = psel & ~penable;
  assign wr_now = psel & penable & pwrite;
  assign pready = 1'b1;

  // Address decode and read value
  always_comb begin
    mapped = 1'b1;
    read_byte = 8'h00;
    unique case (paddr)
      OFS_CONTROL: begin
        read_byte = {oscillator_enable, 1'b0, out_toggle ^ ctrl_pol, ctrl_pol,
                     3'b000, ctrl_pfm};
      end
      OFS_CLK_CFG: read_byte = clk_cfg & CLK_CFG_MASK;
      OFS_ACC_LOW: read_byte = phase_accumulator[7:0]; // see R1
      OFS_ACC_HIGH: read_byte = phase_accumulator[15:8]; // see R1
      OFS_ACC_UPPER: read_byte = {4'h0, phase_accumulator[19:16]}; // see R2 see R3
      OFS_STEP_LOW: read_byte = phase_step[7:0]; // see R6
      OFS_STEP_HIGH: read_byte = phase_step[15:8]; // see R6
      OFS_STEP_UPPER: read_byte = {4'h0, phase_step[19:16]}; // see R2 see R6
      OFS_IRQ_STATUS: read_byte = {7'h00, overflow_flag};
      OFS_IRQ_MASK: read_byte = {7'h00, overflow_irq_enable};
      default: mapped = 1'b0;
    endcase
  end

  // Read data and error are captured in setup, so they come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= {24'h000000, pwrite ? 8'h00 : read_byte};
      pslverr <= ~mapped;
    end
  end

  // Control and clock configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_enable <= 1'b0;
      ctrl_pol <= 1'b0;
      ctrl_pfm <= 1'b0;
      clk_cfg <= CLK_CFG_RESET;
    end else if (wr_now && paddr == OFS_CONTROL) begin
      oscillator_enable <= pwdata[CTRL_ENABLE_BIT];
      ctrl_pol <= pwdata[CTRL_POL_BIT];
      ctrl_pfm <= pwdata[CTRL_PFM_BIT];
    end else if (wr_now && paddr == OFS_CLK_CFG) begin
      clk_cfg <= pwdata[7:0] & CLK_CFG_MASK;
    end
  end

  // Step bytes; the low byte is what arms the shadow load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_step <= STEP_RESET; // see R7
    end else if (wr_now) begin
      unique case (paddr)
        OFS_STEP_LOW: phase_step[7:0] <= pwdata[7:0]; // see R6
        OFS_STEP_HIGH: phase_step[15:8] <= pwdata[7:0]; // see R6
        OFS_STEP_UPPER: phase_step[19:16] <= pwdata[3:0]; // see R6
        default: phase_step <= phase_step;
      endcase
    end
  end
  assign step_low_wr = wr_now && paddr == OFS_STEP_LOW;
  assign step_any_wr = wr_now && (paddr == OFS_STEP_LOW || paddr == OFS_STEP_HIGH ||
                                  paddr == OFS_STEP_UPPER);

  // Accumulator writes go straight to the core
  always_comb begin
    acc_wr.valid = wr_now;
    acc_wr.data = pwdata[7:0];
    acc_wr.lane = LANE_LOW;
    unique case (paddr)
      OFS_ACC_LOW: acc_wr.lane = LANE_LOW;
      OFS_ACC_HIGH: acc_wr.lane = LANE_HIGH;
      OFS_ACC_UPPER: acc_wr.lane = LANE_UPPER;
      default: acc_wr.valid = 1'b0;
    endcase
  end

  // Sticky overflow flag; a new overflow beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (overflow) begin
      overflow_flag <= 1'b1; // see R11
    end else if (wr_now && paddr == OFS_IRQ_STATUS && pwdata[0]) begin
      overflow_flag <= 1'b0; // see R11
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable <= 1'b0;
    end else if (wr_now && paddr == OFS_IRQ_MASK) begin
      overflow_irq_enable <= pwdata[0];
    end
  end

  // Output toggles on each overflow, giving half the overflow rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_toggle <= 1'b0;
      osc_out <= 1'b0;
    end else begin
      if (overflow) begin
        out_toggle <= ~out_toggle;
      end
      osc_out <= out_toggle ^ ctrl_pol;
    end
  end

  // Level interrupt needs the module enabled as well as the mask
  assign irq = overflow_flag & overflow_irq_enable & oscillator_enable; // see R11

  nco_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .enable(oscillator_enable),
    .osc_clk_in(oscillator_input_clock),
    .phase_step(phase_step),
    .step_low_wr(step_low_wr),
    .step_any_wr(step_any_wr),
    .acc_wr(acc_wr),
    .phase_accumulator(phase_accumulator),
    .step_shadow(step_shadow),
    .overflow(overflow)
  );

  a_upper_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    (setup && !pwrite && (paddr == OFS_ACC_UPPER || paddr == OFS_STEP_UPPER))
      |=> prdata[31:4] == 28'h0000000)
    else $error("upper register high bits not zero");
  a_acc_high_lane: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    (setup && !pwrite && paddr == OFS_ACC_HIGH) |=>
      prdata[7:0] == $past(phase_accumulator[15:8]))
    else $error("accumulator high byte read wrong");
  a_step_low_write: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    (wr_now && paddr == OFS_STEP_LOW) |=> phase_step[7:0] == $past(pwdata[7:0]))
    else $error("step low byte not stored");
  a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    overflow |=> overflow_flag ##1 (overflow_flag || $past(wr_now)))
    else $error("overflow flag not set");
  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    (overflow && overflow_irq_enable && oscillator_enable && !wr_now) |=> irq)
    else $error("interrupt not raised");
  c_flag_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(overflow_flag));
  c_bus_error: cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pslverr);
endmodule : nco_regs

// file: dv/phase_accumulator_regs_tb.sv
`timescale 1ns/1ps
module phase_accumulator_regs_tb
  import nco_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, osc, pready, pslverr, osc_out, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed;
  int mismatches, checks_done, cycles;
  int acc_m, step_m, shadow_m;
  bit pend, flag_m, en_m, mask_m, out_m, pol_m, err;

  nco_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscillator_input_clock(osc), .osc_out(osc_out), .irq(irq));

  // 40 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr

  task automatic finish_test();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; one idle edge after it so the next setup never collides
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the hang guard ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input int exp);
    apb(1'b0, a, 8'h00);
    chk("read data", exp, rd);
  endtask : rd_chk

  task automatic acc_chk();
    rd_chk(OFS_ACC_LOW, acc_m & 'hFF);
    rd_chk(OFS_ACC_HIGH, (acc_m >> 8) & 'hFF);
    rd_chk(OFS_ACC_UPPER, acc_m >> 16);
  endtask : acc_chk

  // Upper and high first: the low write arms the shadow load
  task automatic set_step(input int v);
    apb(1'b1, OFS_STEP_UPPER, v >> 16);
    apb(1'b1, OFS_STEP_HIGH, (v >> 8) & 'hFF);
    apb(1'b1, OFS_STEP_LOW, v & 'hFF);
    step_m = v;
    if (en_m) pend = 1;
    else shadow_m = v;
  endtask : set_step

  // One oscillator period, each level held three bus cycles so it is sampled
  task automatic osc_cycle();
    osc <= 1'b1;
    repeat (3) @(posedge pclk);
    if (en_m) begin
      acc_m = acc_m + shadow_m;
      if (acc_m > 'hFFFFF) begin
        acc_m = acc_m - 'h100000;
        flag_m = 1;
        out_m = ~out_m;
      end
    end
    osc <= 1'b0;
    repeat (3) @(posedge pclk);
    if (en_m && pend) begin
      shadow_m = step_m;
      pend = 0;
    end
  endtask : osc_cycle

  task automatic irq_chk();
    rd_chk(OFS_IRQ_STATUS, flag_m);
    chk("irq", flag_m & mask_m & en_m, irq);
    chk("osc_out", out_m ^ pol_m, osc_out);
  endtask : irq_chk

  // Main sequence
  initial begin
    {psel, penable, pwrite, osc} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    seed = 32'h1d65b333;
    {acc_m, step_m, shadow_m} = {32'd0, 32'd1, 32'd1};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc_chk();
    rd_chk(OFS_STEP_LOW, 8'h01);
    rd_chk(OFS_STEP_HIGH, 8'h00);
    rd_chk(OFS_STEP_UPPER, 8'h00);
    irq_chk();
    apb(1'b0, 8'h30, 8'h00);
    chk("pslverr", 1, err);
    chk("unmapped data", 0, rd);
    chk("pready", 1, pready);
    // Unimplemented upper bits stay zero
    apb(1'b1, OFS_ACC_UPPER, 8'hFF);
    rd_chk(OFS_ACC_UPPER, 8'h0F);
    apb(1'b1, OFS_STEP_UPPER, 8'hFF);
    rd_chk(OFS_STEP_UPPER, 8'h0F);
    // Accumulator loaded only while stopped
    seed = lfsr(seed);
    acc_m = seed[19:0];
    apb(1'b1, OFS_ACC_LOW, seed[7:0]);
    apb(1'b1, OFS_ACC_HIGH, seed[15:8]);
    apb(1'b1, OFS_ACC_UPPER, seed[23:16]);
    acc_chk();
    seed = lfsr(seed);
    set_step(seed[19:0] | 'h40000);
    rd_chk(OFS_STEP_HIGH, (step_m >> 8) & 'hFF);
    apb(1'b1, OFS_IRQ_MASK, 8'h01);
    mask_m = 1;
    apb(1'b1, OFS_CONTROL, 8'h80);
    en_m = 1;
    for (int i = 0; i < 6; i++) begin
      repeat (3) osc_cycle();
      acc_chk();
      irq_chk();
      if (i == 2) begin
        apb(1'b1, OFS_IRQ_MASK, 8'h00);
        mask_m = 0;
        irq_chk();
      end
      apb(1'b1, OFS_IRQ_STATUS, 8'h01);
      flag_m = 0;
      irq_chk();
      // New step; the first rise after it still uses the old shadow
      seed = lfsr(seed);
      set_step(seed[19:0] | 'h40000);
    end
    // Polarity inverts the output; the pulse mode bit is only stored
    apb(1'b1, OFS_CONTROL, 8'h91);
    pol_m = 1;
    irq_chk();
    rd_chk(OFS_CONTROL, 'h91 | ((out_m ^ pol_m) << 5));
    // Unimplemented clock configuration bits read as zero
    apb(1'b1, OFS_CLK_CFG, 8'hFF);
    rd_chk(OFS_CLK_CFG, 8'hE3);
    finish_test();
  end
endmodule : phase_accumulator_regs_tb
